// ==== two_wire_serial_master_slave.sv ====
// Two-wire serial bus controller, master and slave roles on one pin pair
`include "tws_params.svh"

// Functional notes
// - Master and slave roles are enabled separately, and both together give multimaster use.
// - With the slave role on, every start condition on the bus opens a new address phase.
// - The master role makes start, repeated start and stop conditions and drives transfers.
// - The master waits for a stretched clock, ends its high phase early and drops out on lost data.
// - With the slave role off, a start made by another agent raises no interrupt.
// - The slave compares the received 7-bit address with its own address in hardware.
// - An address match can raise a wake pulse for the chip's low-power logic.
// - The first byte after a start is a 7-bit address then a direction bit, one meaning read.
// - Each transfer ends with a stop made by the master that owns the bus.
// - An owning master may issue a repeated start without a stop in between.
// - The bit timer defaults to a 1 Mbps bus rate, 5 system clocks per quarter bit.
// - Only 7-bit addresses are compared; ten-bit prefixes are passed on for software.
// - Framing and status are done in hardware and data moves one whole byte at a time.
// - Each event pulse (done, lost, slave start, match, rx, tx request, slave stop) also pulses the interrupt line.
// - Both roles can transmit and receive bytes.
module two_wire_serial_master_slave #(
    parameter int QTR_CYC = `TWS_QTR_CYC
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       master_en,
    input  wire logic       slave_en,
    input  wire logic       ten_bit_en,
    input  wire logic       wake_en,
    input  wire logic [6:0] own_addr,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_start,
    input  wire logic       cmd_byte,
    input  wire logic       cmd_stop,
    input  wire logic       cmd_read,
    input  wire logic       cmd_nack,
    input  wire logic [7:0] cmd_data,
    output logic            cmd_ready_q,
    output logic            m_done_q,
    output logic            m_ack_q,
    output logic [7:0]      m_rdata_q,
    output logic            m_lost_q,
    output logic            bus_busy_q,
    input  wire logic [7:0] s_tx_data,
    output logic            s_start_q,
    output logic            s_match_q,
    output logic            s_dir_q,
    output logic            s_rx_valid_q,
    output logic [7:0]      s_rx_data_q,
    output logic            s_tx_req_q,
    output logic            s_stop_q,
    output logic            wake_q,
    output logic            irq_q,
    input  wire logic       scl_in,
    output logic            scl_out_q,
    output logic            scl_oe_n_q,
    input  wire logic       sda_in,
    output logic            sda_out_q,
    output logic            sda_oe_n_q
);
    tws_pkg::mst_state_t m_st_q;
    tws_pkg::slv_state_t s_st_q;
    logic       scl_p_q;
    logic       sda_p_q;
    logic [7:0] m_tmr_q;
    logic [1:0] m_ph_q;
    logic [3:0] m_bit_q;
    logic [8:0] m_sh_q;
    logic       m_rd_q;
    logic       m_stop_q;
    logic       m_byte_q;
    logic       m_own_q;
    logic       m_scl_low_q;
    logic       m_sda_low_q;
    logic [3:0] s_cnt_q;
    logic [7:0] s_sh_q;
    logic       s_mack_q;
    logic       s_sda_low_q;

    // Bus condition decode from the current and previous samples
    wire scl_rise   = scl_in & ~scl_p_q;
    wire scl_fall   = ~scl_in & scl_p_q;
    wire start_det  = scl_in & scl_p_q & sda_p_q & ~sda_in;
    wire stop_det   = scl_in & scl_p_q & ~sda_p_q & sda_in;

    // Master timing: phase 2 holds while the line is stretched low
    wire m_run      = (m_st_q != tws_pkg::M_IDLE);
    wire m_hold     = (m_ph_q == 2'h2) & ~scl_in;
    wire m_sync     = (m_st_q == tws_pkg::M_BIT) & (m_ph_q == 2'h3) & ~scl_in;
    wire m_tick     = m_run & (((m_tmr_q == 8'h00) & ~m_hold) | m_sync);
    wire m_sending  = m_rd_q ? (m_bit_q == `TWS_ACK_BIT) : (m_bit_q != `TWS_ACK_BIT);
    wire lost_bit   = (m_st_q == tws_pkg::M_BIT) & ~m_sda_low_q & m_sending;
    wire lost_start = (m_st_q == tws_pkg::M_START);
    wire m_lost     = m_tick & (m_ph_q == 2'h2) & ~sda_in & (lost_bit | lost_start);
    wire m_last     = (m_st_q == tws_pkg::M_BIT) & (m_ph_q == 2'h3);
    wire m_done     = m_tick & m_last & (m_bit_q == `TWS_ACK_BIT);
    wire take       = cmd_valid & cmd_ready_q;
    wire [7:0] qtr  = 8'(QTR_CYC - 1);

    // Slave decode
    wire s_on       = (s_st_q != tws_pkg::S_IDLE);
    wire s_rd       = (s_st_q == tws_pkg::S_RD);
    wire s_adr      = (s_st_q == tws_pkg::S_ADDR);
    wire adr_own    = (s_sh_q[7:1] == own_addr);
    wire adr_ten    = ten_bit_en & (s_sh_q[7:3] == `TWS_TENBIT_PFX);
    wire adr_ok     = adr_own | adr_ten;
    wire f8         = s_on & scl_fall & (s_cnt_q == `TWS_ACK_BIT);
    wire f9         = s_on & scl_fall & (s_cnt_q == `TWS_END_BIT);
    wire s_go_rd    = (s_adr & s_dir_q) | (s_rd & s_mack_q);
    wire ev_sstart  = start_det & slave_en;
    wire ev_match   = f8 & s_adr & adr_ok;
    wire ev_rx      = f8 & (s_st_q == tws_pkg::S_WR);
    wire ev_tx      = f9 & s_go_rd;
    wire ev_sstop   = stop_det & s_on;
    wire ev_any     = m_done | m_lost | ev_sstart | ev_match | ev_rx | ev_tx | ev_sstop;

    // Line history and bus ownership by anyone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            bus_busy_q <= 1'b0;
        end else begin
            scl_p_q    <= scl_in;
            sda_p_q    <= sda_in;
            bus_busy_q <= start_det | (bus_busy_q & ~stop_det);
        end
    end

    // Quarter-bit timer, reloaded on every phase step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_tmr_q <= 8'h00;
        end else if (!m_run || m_tick || take) begin
            m_tmr_q <= qtr;
        end else if (m_tmr_q != 8'h00) begin
            m_tmr_q <= m_tmr_q - 8'h01;
        end
    end

    // Master sequencer, one action per quarter-bit phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_st_q      <= tws_pkg::M_IDLE;
            m_ph_q      <= 2'h0;
            m_bit_q     <= 4'h0;
            m_sh_q      <= 9'h1FF;
            m_rd_q      <= 1'b0;
            m_stop_q    <= 1'b0;
            m_byte_q    <= 1'b0;
            m_own_q     <= 1'b0;
            m_scl_low_q <= 1'b0;
            m_sda_low_q <= 1'b0;
            m_ack_q     <= 1'b0;
            m_rdata_q   <= 8'h00;
        end else if (m_lost) begin
            // Drop both lines at once so the winner sees a clean bus
            m_st_q      <= tws_pkg::M_IDLE;
            m_own_q     <= 1'b0;
            m_scl_low_q <= 1'b0;
            m_sda_low_q <= 1'b0;
        end else if (take) begin
            m_sh_q   <= cmd_read ? {8'hFF, cmd_nack} : {cmd_data, 1'b1};
            m_rd_q   <= cmd_read;
            m_stop_q <= cmd_stop;
            m_byte_q <= cmd_byte;
            m_bit_q  <= 4'h0;
            m_ph_q   <= 2'h0;
            if (cmd_start) begin
                m_st_q <= tws_pkg::M_START;
            end else if (!m_own_q) begin
                m_st_q <= tws_pkg::M_IDLE;
            end else if (cmd_byte) begin
                m_st_q <= tws_pkg::M_BIT;
            end else if (cmd_stop) begin
                m_st_q <= tws_pkg::M_STOP;
            end
        end else if (m_tick) begin
            m_ph_q <= m_ph_q + 2'h1;
            case (m_st_q)
                tws_pkg::M_START: begin
                    case (m_ph_q)
                        2'h0: m_sda_low_q <= 1'b0;
                        2'h1: m_scl_low_q <= 1'b0;
                        2'h2: begin
                            m_sda_low_q <= 1'b1;
                            m_own_q     <= 1'b1;
                        end
                        default: begin
                            m_scl_low_q <= 1'b1;
                            if (m_byte_q) begin
                                m_st_q <= tws_pkg::M_BIT;
                            end else begin
                                m_st_q <= m_stop_q ? tws_pkg::M_STOP : tws_pkg::M_IDLE;
                            end
                        end
                    endcase
                end
                tws_pkg::M_BIT: begin
                    case (m_ph_q)
                        2'h0: m_sda_low_q <= ~m_sh_q[8];
                        2'h1: m_scl_low_q <= 1'b0;
                        2'h2: begin
                            if (m_bit_q == `TWS_ACK_BIT) begin
                                m_ack_q <= ~sda_in;
                            end else begin
                                m_rdata_q <= {m_rdata_q[6:0], sda_in};
                            end
                        end
                        default: begin
                            m_scl_low_q <= 1'b1;
                            m_sh_q      <= {m_sh_q[7:0], 1'b1};
                            if (m_bit_q == `TWS_ACK_BIT) begin
                                m_st_q <= m_stop_q ? tws_pkg::M_STOP : tws_pkg::M_IDLE;
                            end else begin
                                m_bit_q <= m_bit_q + 4'h1;
                            end
                        end
                    endcase
                end
                tws_pkg::M_STOP: begin
                    case (m_ph_q)
                        2'h0: m_sda_low_q <= 1'b1;
                        2'h1: m_scl_low_q <= 1'b0;
                        2'h2: m_sda_low_q <= 1'b0;
                        default: begin
                            m_st_q  <= tws_pkg::M_IDLE;
                            m_own_q <= 1'b0;
                        end
                    endcase
                end
                default: m_st_q <= tws_pkg::M_IDLE;
            endcase
        end
    end

    // Command acceptance: a foreign-owned bus is never interrupted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_ready_q <= 1'b0;
        end else begin
            cmd_ready_q <= master_en & ~m_run & ~take & ~m_lost & (m_own_q | ~bus_busy_q);
        end
    end

    // Slave engine; no clock stretching, so s_tx_data must be ready in time
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_st_q      <= tws_pkg::S_IDLE;
            s_cnt_q     <= 4'h0;
            s_sh_q      <= 8'h00;
            s_mack_q    <= 1'b0;
            s_sda_low_q <= 1'b0;
            s_dir_q     <= 1'b0;
        end else if (!slave_en || stop_det) begin
            s_st_q      <= tws_pkg::S_IDLE;
            s_sda_low_q <= 1'b0;
        end else if (start_det) begin
            s_st_q      <= tws_pkg::S_ADDR;
            s_cnt_q     <= 4'h0;
            s_sda_low_q <= 1'b0;
        end else if (s_on && scl_rise && s_cnt_q != `TWS_END_BIT) begin
            s_cnt_q <= s_cnt_q + 4'h1;
            if (!s_rd && s_cnt_q != `TWS_ACK_BIT) begin
                s_sh_q <= {s_sh_q[6:0], sda_in};
            end
            if (s_rd && s_cnt_q == `TWS_ACK_BIT) begin
                s_mack_q <= ~sda_in;
            end
        end else if (f8) begin
            if (s_adr && !adr_ok) begin
                s_st_q <= tws_pkg::S_IDLE;
            end else begin
                s_sda_low_q <= ~s_rd;
            end
            if (s_adr) begin
                s_dir_q <= s_sh_q[0];
            end
        end else if (f9) begin
            s_cnt_q <= 4'h0;
            if (s_go_rd) begin
                s_st_q      <= tws_pkg::S_RD;
                s_sh_q      <= s_tx_data;
                s_sda_low_q <= ~s_tx_data[7];
            end else begin
                s_st_q      <= s_rd ? tws_pkg::S_IDLE : tws_pkg::S_WR;
                s_sda_low_q <= 1'b0;
            end
        end else if (s_rd && scl_fall && s_cnt_q != 4'h0) begin
            s_sh_q      <= {s_sh_q[6:0], 1'b0};
            s_sda_low_q <= ~s_sh_q[6];
        end
    end

    // Event pulses and the shared interrupt line
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m_done_q     <= 1'b0;
            m_lost_q     <= 1'b0;
            s_start_q    <= 1'b0;
            s_match_q    <= 1'b0;
            s_rx_valid_q <= 1'b0;
            s_rx_data_q  <= 8'h00;
            s_tx_req_q   <= 1'b0;
            s_stop_q     <= 1'b0;
            wake_q       <= 1'b0;
            irq_q        <= 1'b0;
        end else begin
            m_done_q     <= m_done;
            m_lost_q     <= m_lost;
            s_start_q    <= ev_sstart;
            s_match_q    <= ev_match;
            s_rx_valid_q <= ev_rx;
            s_rx_data_q  <= ev_rx ? s_sh_q : s_rx_data_q;
            s_tx_req_q   <= ev_tx;
            s_stop_q     <= ev_sstop;
            wake_q       <= ev_match & wake_en;
            irq_q        <= ev_any;
        end
    end

    // Pin drivers; a one-cycle lag keeps every output on a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_out_q  <= 1'b0;
            sda_out_q  <= 1'b0;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            scl_out_q  <= 1'b0;
            sda_out_q  <= 1'b0;
            scl_oe_n_q <= ~m_scl_low_q;
            sda_oe_n_q <= ~(m_sda_low_q | s_sda_low_q);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_start_gated: assert property (s_start_q |-> $past(slave_en))
        else $error("start event with slave role off");
    a_pins_low_only: assert property (!scl_out_q && !sda_out_q)
        else $error("bus line driven high");
    a_addr_compare: assert property (s_match_q |->
        ($past(s_sh_q[7:1]) == $past(own_addr)) ||
        ($past(ten_bit_en) && $past(s_sh_q[7:3]) == `TWS_TENBIT_PFX))
        else $error("match without address equality");
    a_wake_on_match: assert property (wake_q |-> s_match_q && $past(wake_en))
        else $error("wake without enabled match");
    a_rx_ack_drive: assert property (s_rx_valid_q |=> !sda_oe_n_q)
        else $error("received byte not acknowledged");
    a_stop_release: assert property ($fell(m_own_q) |-> m_lost_q ||
        $past(m_st_q) == tws_pkg::M_STOP)
        else $error("ownership ended without stop");
    a_arb_lost_idle: assert property (m_lost_q |-> !m_scl_low_q && !m_sda_low_q &&
        m_st_q == tws_pkg::M_IDLE)
        else $error("lines held after lost arbitration");
    a_byte_whole: assert property (m_done_q |-> $past(m_bit_q) == `TWS_ACK_BIT)
        else $error("byte done before ninth bit");
    a_sda_high_hold: assert property (m_st_q == tws_pkg::M_BIT && m_ph_q == 2'h3 &&
        $past(m_ph_q) == 2'h3 |-> $stable(m_sda_low_q))
        else $error("data changed while clock high");
    a_irq_cause: assert property (irq_q |-> m_done_q || m_lost_q || s_start_q ||
        s_match_q || s_rx_valid_q || s_tx_req_q || s_stop_q)
        else $error("interrupt without event");
    a_master_gate: assert property ($rose(m_run) |-> $past(master_en, 2))
        else $error("master started while disabled");

    c_slave_match: cover property (s_match_q && s_dir_q);
    c_master_byte: cover property (m_done_q && m_ack_q);
    c_arb_lost:    cover property (m_lost_q);
    c_slave_read:  cover property (s_tx_req_q);
endmodule

// ==== two_wire_serial_master_slave_tb.sv ====
// Self-checking bench for the two-wire serial controller
module two_wire_serial_master_slave_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] a; logic [7:0] d; logic ack;} row_t;
    logic clk = 1'b0, resetn = 1'b0, master_en = 1'b1, slave_en = 1'b0;
    logic ten_bit_en = 1'b0, wake_en = 1'b0, cmd_valid = 1'b0, cmd_start = 1'b0;
    logic cmd_byte = 1'b0, cmd_stop = 1'b0, cmd_read = 1'b0, cmd_nack = 1'b0;
    logic [6:0] own_addr = 7'h2A;
    logic [7:0] cmd_data = 8'h00, tx_b = 8'h00, p_rx, s_rx_data_q, m_rdata_q, last_rx = 8'h00;
    logic cmd_ready_q, m_done_q, m_ack_q, m_lost_q, bus_busy_q, s_start_q, s_match_q;
    logic s_dir_q, s_rx_valid_q, s_tx_req_q, s_stop_q, wake_q, irq_q, p_oe_n;
    logic scl_out_q, scl_oe_n_q, sda_out_q, sda_oe_n_q, scl_w, sda_w;
    logic ext_sda_n = 1'b1;
    int n_mismatch = 0, n_checks = 0, cyc = 0, n_st = 0, n_m = 0, n_wk = 0, n_sp = 0;
    int n_bad = 0, n_tx = 0, n_lost = 0, p_stop, s0;
    row_t rows[4] = '{'{8'hA4, 8'hA5, 1'b1}, '{8'hA4, 8'h00, 1'b1},
                      '{8'hA6, 8'h5A, 1'b0}, '{8'hA5, 8'hC3, 1'b1}};
    // Open-drain wires: low when any party pulls, else pull-up
    assign scl_w = scl_oe_n_q;
    assign sda_w = sda_oe_n_q & p_oe_n & ext_sda_n; // Third pull stands in for a rival master
    two_wire_serial_master_slave #(.QTR_CYC(2)) two_wire_serial_master_slave_i (
        .clk(clk), .resetn(resetn), .master_en(master_en), .slave_en(slave_en),
        .ten_bit_en(ten_bit_en), .wake_en(wake_en), .own_addr(own_addr),
        .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_byte(cmd_byte),
        .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_data(cmd_data),
        .cmd_ready_q(cmd_ready_q), .m_done_q(m_done_q), .m_ack_q(m_ack_q),
        .m_rdata_q(m_rdata_q), .m_lost_q(m_lost_q), .bus_busy_q(bus_busy_q),
        .s_tx_data(tx_b), .s_start_q(s_start_q), .s_match_q(s_match_q), .s_dir_q(s_dir_q),
        .s_rx_valid_q(s_rx_valid_q), .s_rx_data_q(s_rx_data_q), .s_tx_req_q(s_tx_req_q),
        .s_stop_q(s_stop_q), .wake_q(wake_q), .irq_q(irq_q), .scl_in(scl_w),
        .scl_out_q(scl_out_q), .scl_oe_n_q(scl_oe_n_q), .sda_in(sda_w),
        .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q));
    tws_slave_model #(.ADDR(7'h52)) tws_slave_model_i (.clk(clk), .scl(scl_w), .sda(sda_w),
        .tx_byte(tx_b), .sda_oe_n(p_oe_n), .rx_byte(p_rx), .n_stop(p_stop));
    initial begin
        forever #25 clk = ~clk;
    end
    // Event pulses counted where settled; a lost pulse would show as a short count
    always @(negedge clk) begin
        if (s_start_q === 1'b1) n_st++;
        if (s_match_q === 1'b1) n_m++;
        if (wake_q === 1'b1) n_wk++;
        if (s_stop_q === 1'b1) n_sp++;
        if (s_tx_req_q === 1'b1) n_tx++;
        if (m_lost_q === 1'b1) n_lost++;
        if (s_rx_valid_q === 1'b1) last_rx = s_rx_data_q;
        if ((s_match_q === 1'b1 || m_done_q === 1'b1) && irq_q !== 1'b1) n_bad++;
    end
    // Hang guard, well above the fewer than two thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One command, entered at a falling edge; held until taken, then waits for the byte
    task automatic cmd(input logic st, by, sp, rd, input logic [7:0] d);
        int w;
        {cmd_start, cmd_byte, cmd_stop, cmd_read, cmd_nack, cmd_data} = {st, by, sp, rd, rd, d};
        cmd_valid = 1'b1;
        w = 0;
        while (cmd_ready_q !== 1'b1 && w < 2000) begin
            @(negedge clk);
            w++;
        end
        if (w >= 2000) n_mismatch++;
        @(negedge clk);
        cmd_valid = 1'b0;
        w = 0;
        // A lost arbitration also ends the byte early
        while (by && m_done_q !== 1'b1 && m_lost_q !== 1'b1 && w < 2000) begin
            @(negedge clk);
            w++;
        end
        if (w >= 2000) n_mismatch++;
    endtask
    task automatic idle();
        repeat (2) @(negedge clk);
        while (cmd_ready_q !== 1'b1 && cyc < 19000) @(negedge clk);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        chk("scl_oe_n", 8'h01, 8'(scl_oe_n_q));
        chk("sda_oe_n", 8'h01, 8'(sda_oe_n_q));
        chk("ready in reset", 8'h00, 8'(cmd_ready_q));
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        chk("ready after reset", 8'h01, 8'(cmd_ready_q));
        // Table: address byte, then data write, read with nack, or stop alone
        foreach (rows[i]) begin
            tx_b = rows[i].d;
            cmd(1'b1, 1'b1, 1'b0, 1'b0, rows[i].a);
            chk("addr ack", {7'h00, rows[i].ack}, 8'(m_ack_q));
            if (!rows[i].ack) cmd(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
            else if (rows[i].a[0]) begin
                cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
                chk("read byte", rows[i].d, m_rdata_q);
            end else begin
                cmd(1'b0, 1'b1, 1'b1, 1'b0, rows[i].d);
                chk("written byte", rows[i].d, p_rx);
                chk("data ack", 8'h01, 8'(m_ack_q));
            end
            idle();
            chk("busy after stop", 8'h00, 8'(bus_busy_q));
            chk("stop count", 8'(i + 1), 8'(p_stop));
        end
        chk("starts with slave off", 8'h00, 8'(n_st));
        // Repeated start: write then read with a single stop
        s0 = p_stop;
        tx_b = 8'h96;
        cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'hA4);
        cmd(1'b0, 1'b1, 1'b0, 1'b0, 8'h11);
        cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'hA5);
        cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        idle();
        chk("rs write", 8'h11, p_rx);
        chk("rs read", 8'h96, m_rdata_q);
        chk("rs stops", 8'(s0 + 1), 8'(p_stop));
        // Ten-bit prefix acked and flagged as a match only when enabled
        slave_en = 1'b1;
        for (int t = 1; t >= 0; t--) begin
            ten_bit_en = t[0];
            cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'hF0);
            chk("prefix ack", 8'(t), 8'(m_ack_q));
            cmd(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
            idle();
        end
        chk("slave starts", 8'h02, 8'(n_st));
        chk("prefix match", 8'h01, 8'(n_m));
        // Own address: hardware match, wake, byte received by the slave role
        wake_en = 1'b1;
        cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'h54);
        chk("own ack", 8'h01, 8'(m_ack_q));
        cmd(1'b0, 1'b1, 1'b1, 1'b0, 8'h69);
        idle();
        chk("match", 8'h02, 8'(n_m));
        chk("wake", 8'h01, 8'(n_wk));
        chk("slave rx", 8'h69, last_rx);
        chk("slave dir", 8'h00, 8'(s_dir_q));
        chk("slave stop", 8'h01, 8'(n_sp > 0));
        chk("irq with events", 8'h00, 8'(n_bad));
        chk("lines low only", 8'h00, {6'h00, scl_out_q, sda_out_q});
        // Slave role answers a read of its own address with its byte
        tx_b = 8'hB1;
        cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'h55);
        chk("slave read dir", 8'h01, 8'(s_dir_q));
        cmd(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        chk("slave tx byte", 8'hB1, m_rdata_q);
        idle();
        chk("slave tx req", 8'h01, 8'(n_tx));
        // A rival holds data low under a sent one: the master must drop out
        cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'hA4);
        @(negedge clk);
        ext_sda_n = 1'b0;
        cmd(1'b0, 1'b1, 1'b1, 1'b0, 8'hFF);
        repeat (2) @(negedge clk);
        chk("lost count", 8'h01, 8'(n_lost));
        chk("lines freed", 8'h03, {6'h00, scl_oe_n_q, sda_oe_n_q});
        ext_sda_n = 1'b1;
        idle();
        chk("busy after lost", 8'h00, 8'(bus_busy_q));
        // Master role off refuses commands
        master_en = 1'b0;
        repeat (3) @(negedge clk);
        chk("ready master off", 8'h00, 8'(cmd_ready_q));
        tally_and_finish();
    end
endmodule

// ==== tws_params.svh ====
// Timing and framing constants for the two-wire serial controller
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_CLK_NS      50
`define TWS_BIT_NS      1000
`define TWS_QTR_CYC     ((`TWS_BIT_NS / 4 + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_TENBIT_PFX  5'h1E
`define TWS_ACK_BIT     4'h8
`define TWS_END_BIT     4'h9
`endif

// ==== tws_pkg.sv ====
// State types for the two-wire serial controller
package tws_pkg;
    typedef enum logic [3:0] {
        M_IDLE  = 4'b0001,
        M_START = 4'b0010,
        M_BIT   = 4'b0100,
        M_STOP  = 4'b1000
    } mst_state_t;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_ADDR = 4'b0010,
        S_WR   = 4'b0100,
        S_RD   = 4'b1000
    } slv_state_t;
endpackage

// ==== tws_slave_model.sv ====
// Behavioural far-side bus slave for the controller bench
module tws_slave_model #(
    parameter logic [6:0] ADDR = 7'h52
) (
    input  wire logic       clk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [7:0] tx_byte,
    output logic            sda_oe_n = 1'b1,
    output logic [7:0]      rx_byte = 8'h00,
    output int              n_stop = 0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       pscl = 1'b1;
    logic       psda = 1'b1;
    logic [7:0] sh = 8'h00;
    logic [3:0] cnt = 4'h0;
    logic [1:0] ph = 2'h0;
    logic       dir = 1'b0;
    logic [1:0] nph;
    // Phase after the ack clock: 1 address, 2 write data, 3 read data
    assign nph = (ph == 2'h1) ? (dir ? 2'h3 : 2'h2) : ph;
    // Line edges sampled on the system clock; no clock stretching
    always @(posedge clk) begin
        pscl <= scl;
        psda <= sda;
        if (scl && pscl && psda && !sda) begin
            ph <= 2'h1; // Start opens an address byte
            cnt <= 4'h0;
            sda_oe_n <= 1'b1;
        end else if (scl && pscl && !psda && sda) begin
            ph <= 2'h0; // Stop frees the slave
            sda_oe_n <= 1'b1;
            n_stop <= n_stop + 1;
        end else if (scl && !pscl && ph != 2'h0) begin
            cnt <= cnt + 4'h1;
            if (cnt < 4'h8) sh <= {sh[6:0], sda}; // MSB first
            else if (ph == 2'h3 && sda) ph <= 2'h0; // Master nack ends read
        end else if (!scl && pscl && ph != 2'h0) begin
            if (cnt == 4'h8) begin
                // Ack address match or written byte, else release
                sda_oe_n <= !(ph == 2'h2 || (ph == 2'h1 && sh[7:1] == ADDR));
                if (ph == 2'h2) rx_byte <= sh;
                if (ph == 2'h1) dir <= sh[0]; // One means read
                if (ph == 2'h1 && sh[7:1] != ADDR) ph <= 2'h0;
            end else if (cnt == 4'h9) begin
                cnt <= 4'h0;
                ph <= nph;
                sda_oe_n <= (nph == 2'h3) ? tx_byte[7] : 1'b1;
            end else if (ph == 2'h3) begin
                sda_oe_n <= tx_byte[3'h7 - cnt[2:0]]; // Ones left to the pull-up
            end
        end
    end
endmodule
